/* logic/pcsia_core.sv */
// Program counter, return stack and indirect address decode with APB access.
// Assumes decoder and memory on sys_clk; memory answers the cycle after strobe.
`timescale 1ns/1ps
`default_nettype none
module pcsia_core (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     porReset,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire pcsia_pkg::pcsia_core_op_t coreOp,
    output logic [14:0]                   pcOut,
    output logic                          stackFaultReset,
    output pcsia_pkg::pcsia_mem_req_t     memReq,
    input  wire logic [7:0]               memRdata
);
    // Register access phases
    typedef enum logic [2:0] {
        PCSIA_BUS_IDLE, PCSIA_BUS_MEM, PCSIA_BUS_READ, PCSIA_BUS_EXTRA, PCSIA_BUS_DONE
    } pcsia_bus_t;

    // Indirect decode result
    typedef struct packed {
        logic                   hit;      // Real location behind it
        logic                   readOnly; // Writes dropped
        logic                   slow;     // One extra cycle
        pcsia_pkg::pcsia_space_t space;
        logic [14:0]            addr;
    } pcsia_decode_t;

    // Whole module state
    typedef struct packed {
        logic [14:0]                 pc;            // Program counter
        logic [6:0]                  upperLatch;    // High latch
        logic [15:0]                 indAddr0;      // Indirect address 0
        logic [15:0]                 indAddr1;      // Indirect address 1
        logic [4:0]                  stackPtr;      // Entry in use
        logic [15:0][14:0]           stack;         // Return stack
        logic                        faultRstEn;    // Stack fault reset enable
        logic                        overflow;      // Sticky overflow
        logic                        underflow;     // Sticky underflow
        logic                        faultPulse;    // Reset request
        pcsia_bus_t                  bus;           // Access phase
        pcsia_decode_t               dec;           // Latched decode
        logic [31:0]                 rdata;         // Read data
        logic                        err;           // Unmapped access
        pcsia_pkg::pcsia_mem_req_t   mem;           // Memory request
    } pcsia_state_t;

    pcsia_state_t s;      // Registered state
    pcsia_state_t next_s; // Next state

    // Maps a 16-bit indirect address to a memory location
    function automatic pcsia_decode_t decodeAddr(input logic [15:0] a);
        pcsia_decode_t d;
        logic [11:0]   off;
        logic [11:0]   bank;
        logic [11:0]   idx;
        d = '0;
        off = a[11:0];
        bank = off / pcsia_pkg::LINEAR_BLOCK;
        idx = off % pcsia_pkg::LINEAR_BLOCK;
        if (a[15]) begin
            // Flash, low byte only, read-only, slow
            d.hit = 1'b1;
            d.readOnly = 1'b1;
            d.slow = 1'b1;
            d.space = pcsia_pkg::PCSIA_SPACE_FLASH;
            d.addr = a[14:0];
        end else if (a[15:8] == pcsia_pkg::EEPROM_HIGH) begin
            // EEPROM window, read-only, slow
            d.hit = 1'b1;
            d.readOnly = 1'b1;
            d.slow = 1'b1;
            d.space = pcsia_pkg::PCSIA_SPACE_EEPROM;
            d.addr = {7'h00, a[7:0]};
        end else if (a <= pcsia_pkg::BANKED_LAST) begin
            // Banked address; port slots are void
            d.hit = (a[6:0] >= pcsia_pkg::PORT_SLOTS);
            d.space = pcsia_pkg::PCSIA_SPACE_DATA;
            d.addr = {2'b00, a[12:0]};
        end else if (a >= pcsia_pkg::LINEAR_BASE && a <= pcsia_pkg::LINEAR_LAST) begin
            // Linear region skips common bytes
            d.hit = (bank[6:0] < pcsia_pkg::LINEAR_BANKS);
            d.space = pcsia_pkg::PCSIA_SPACE_DATA;
            d.addr = {2'b00, bank[5:0], 7'h00} + {2'b00, pcsia_pkg::GPR_OFFSET} + {3'b000, idx};
        end
        return d;
    endfunction

    // APB request decode
    logic [7:0]  regIdx;     // Register index
    logic        accessNow;  // Access phase seen
    logic        wordOk;     // Index mapped
    logic        isPort;     // Indirect data port
    logic [15:0] portAddr;   // Address used by the port
    logic [14:0] pcNext;     // Incremented PC
    logic [14:0] topEntry;   // Entry at the pointer

    assign regIdx    = paddr[9:2];
    assign accessNow = psel && penable;
    assign isPort    = (regIdx == pcsia_pkg::IDX_INDIRECT_PORT0) || (regIdx == pcsia_pkg::IDX_INDIRECT_PORT1);
    assign portAddr  = (regIdx == pcsia_pkg::IDX_INDIRECT_PORT1) ? s.indAddr1 : s.indAddr0;
    assign pcNext    = s.pc + 15'h0001;
    assign topEntry  = s.stack[s.stackPtr[3:0]];

    // Mapped register indices
    always_comb begin
        case (regIdx)
            pcsia_pkg::IDX_INDIRECT_PORT0, pcsia_pkg::IDX_INDIRECT_PORT1,
            pcsia_pkg::IDX_PC_LOW_BYTE, pcsia_pkg::IDX_IND_ADDR0_LOW,
            pcsia_pkg::IDX_IND_ADDR0_HIGH, pcsia_pkg::IDX_IND_ADDR1_LOW,
            pcsia_pkg::IDX_IND_ADDR1_HIGH, pcsia_pkg::IDX_PC_UPPER_LATCH,
            pcsia_pkg::IDX_STACK_POINTER, pcsia_pkg::IDX_STACK_TOP_LOW,
            pcsia_pkg::IDX_STACK_TOP_HIGH, pcsia_pkg::IDX_STACK_CONTROL: begin
                wordOk = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
            end
            default: begin
                wordOk = 1'b0;
            end
        endcase
    end

    // Next state: bus, core ops, stack
    always_comb begin
        logic        busWrite; // Write completes now
        logic [7:0]  wByte;    // Written byte
        logic        overNow;  // Overflow this cycle
        logic        underNow; // Underflow this cycle
        logic [4:0]  ptrUp;    // Pointer after push
        busWrite = 1'b0;
        wByte = pwdata[7:0];
        overNow = 1'b0;
        underNow = 1'b0;
        ptrUp = s.stackPtr + 5'h01;
        next_s = s;
        next_s.faultPulse = 1'b0;
        next_s.mem.strobe = 1'b0;

        // Bus access phases
        case (s.bus)
            PCSIA_BUS_IDLE: begin
                if (accessNow) begin
                    next_s.bus = PCSIA_BUS_DONE;
                    next_s.err = !wordOk;
                    next_s.rdata = '0;
                    if (wordOk && isPort) begin
                        // Indirect access starts a memory cycle
                        next_s.dec = decodeAddr(portAddr);
                        next_s.mem.strobe = next_s.dec.hit && !(pwrite && next_s.dec.readOnly);
                        next_s.mem.write = pwrite;
                        next_s.mem.space = next_s.dec.space;
                        next_s.mem.addr = next_s.dec.addr;
                        next_s.mem.wdata = wByte;
                        next_s.bus = PCSIA_BUS_MEM;
                    end else if (wordOk && !pwrite) begin
                        // Plain register read
                        case (regIdx)
                            pcsia_pkg::IDX_PC_LOW_BYTE: next_s.rdata[7:0] = s.pc[7:0];
                            pcsia_pkg::IDX_IND_ADDR0_LOW: next_s.rdata[7:0] = s.indAddr0[7:0];
                            pcsia_pkg::IDX_IND_ADDR0_HIGH: next_s.rdata[7:0] = s.indAddr0[15:8];
                            pcsia_pkg::IDX_IND_ADDR1_LOW: next_s.rdata[7:0] = s.indAddr1[7:0];
                            pcsia_pkg::IDX_IND_ADDR1_HIGH: next_s.rdata[7:0] = s.indAddr1[15:8];
                            pcsia_pkg::IDX_PC_UPPER_LATCH: next_s.rdata[6:0] = s.upperLatch;
                            pcsia_pkg::IDX_STACK_POINTER: next_s.rdata[4:0] = s.stackPtr;
                            pcsia_pkg::IDX_STACK_TOP_LOW: next_s.rdata[7:0] = topEntry[7:0];
                            pcsia_pkg::IDX_STACK_TOP_HIGH: next_s.rdata[6:0] = topEntry[14:8];
                            pcsia_pkg::IDX_STACK_CONTROL: begin
                                next_s.rdata[pcsia_pkg::BIT_FAULT_RST_EN] = s.faultRstEn;
                                next_s.rdata[pcsia_pkg::BIT_OVERFLOW] = s.overflow;
                                next_s.rdata[pcsia_pkg::BIT_UNDERFLOW] = s.underflow;
                            end
                            default: next_s.rdata = '0;
                        endcase
                    end
                end
            end
            PCSIA_BUS_MEM: begin
                // Strobe stands now; the answer comes next cycle
                next_s.bus = PCSIA_BUS_READ;
            end
            PCSIA_BUS_READ: begin
                // Memory answers now; void locations read zero
                next_s.rdata = {24'h00_0000, s.dec.hit ? memRdata : 8'h00};
                next_s.bus = s.dec.slow ? PCSIA_BUS_EXTRA : PCSIA_BUS_DONE;
            end
            PCSIA_BUS_EXTRA: begin
                // Extra cycle for flash and EEPROM
                next_s.bus = PCSIA_BUS_DONE;
            end
            PCSIA_BUS_DONE: begin
                // Transfer completes this edge
                next_s.bus = PCSIA_BUS_IDLE;
                busWrite = accessNow && pwrite && !s.err;
            end
            default: begin
                next_s.bus = PCSIA_BUS_IDLE;
            end
        endcase

        // Register writes at completion
        if (busWrite) begin
            case (regIdx)
                pcsia_pkg::IDX_PC_LOW_BYTE: next_s.pc = {s.upperLatch, wByte};
                pcsia_pkg::IDX_IND_ADDR0_LOW: next_s.indAddr0[7:0] = wByte;
                pcsia_pkg::IDX_IND_ADDR0_HIGH: next_s.indAddr0[15:8] = wByte;
                pcsia_pkg::IDX_IND_ADDR1_LOW: next_s.indAddr1[7:0] = wByte;
                pcsia_pkg::IDX_IND_ADDR1_HIGH: next_s.indAddr1[15:8] = wByte;
                pcsia_pkg::IDX_PC_UPPER_LATCH: next_s.upperLatch = wByte[6:0];
                pcsia_pkg::IDX_STACK_POINTER: next_s.stackPtr = wByte[4:0];
                pcsia_pkg::IDX_STACK_TOP_LOW: next_s.stack[s.stackPtr[3:0]][7:0] = wByte;
                pcsia_pkg::IDX_STACK_TOP_HIGH: next_s.stack[s.stackPtr[3:0]][14:8] = wByte[6:0];
                pcsia_pkg::IDX_STACK_CONTROL: begin
                    // Flags clear on zero
                    next_s.faultRstEn = wByte[pcsia_pkg::BIT_FAULT_RST_EN];
                    next_s.overflow = s.overflow && wByte[pcsia_pkg::BIT_OVERFLOW];
                    next_s.underflow = s.underflow && wByte[pcsia_pkg::BIT_UNDERFLOW];
                end
                default: ;
            endcase
        end

        // Core ops win over a bus write
        if (coreOp.valid) begin
            case (coreOp.kind)
                pcsia_pkg::PCSIA_OP_FETCH: begin
                    next_s.pc = pcNext;
                end
                pcsia_pkg::PCSIA_OP_WRITE_LOW: begin
                    next_s.pc = {s.upperLatch, coreOp.result};
                end
                pcsia_pkg::PCSIA_OP_CALL, pcsia_pkg::PCSIA_OP_CALL_W, pcsia_pkg::PCSIA_OP_INT_VECTOR: begin
                    // Push: bump pointer, then store
                    overNow = (s.stackPtr == pcsia_pkg::STACK_PTR_FULL);
                    next_s.stackPtr = ptrUp;
                    next_s.stack[ptrUp[3:0]] = pcNext;
                    case (coreOp.kind)
                        pcsia_pkg::PCSIA_OP_CALL: begin
                            next_s.pc = {s.upperLatch[6:3], coreOp.operand};
                        end
                        pcsia_pkg::PCSIA_OP_CALL_W: begin
                            next_s.pc = {s.upperLatch, coreOp.working};
                        end
                        default: begin
                            next_s.pc = pcsia_pkg::INT_VECTOR;
                        end
                    endcase
                end
                pcsia_pkg::PCSIA_OP_RETURN, pcsia_pkg::PCSIA_OP_RETURN_LIT, pcsia_pkg::PCSIA_OP_RETURN_INT: begin
                    // Pop: read entry, then lower pointer
                    underNow = (s.stackPtr == pcsia_pkg::STACK_PTR_EMPTY);
                    next_s.pc = topEntry;
                    next_s.stackPtr = s.stackPtr - 5'h01;
                end
                pcsia_pkg::PCSIA_OP_BRANCH_W: begin
                    next_s.pc = pcNext + {7'h00, coreOp.working};
                end
                pcsia_pkg::PCSIA_OP_BRANCH_REL: begin
                    next_s.pc = pcNext + {{6{coreOp.operand[8]}}, coreOp.operand[8:0]};
                end
                default: begin
                    next_s.pc = s.pc;
                end
            endcase
        end

        // Sticky flags; event wins over clear
        if (overNow) begin
            next_s.overflow = 1'b1;
        end
        if (underNow) begin
            next_s.underflow = 1'b1;
        end
        // Fault reset request when enabled
        next_s.faultPulse = (overNow || underNow) && s.faultRstEn;
    end

    // State register; flags survive all resets but power-on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
            s.pc <= pcsia_pkg::PC_RESET;
            s.stackPtr <= pcsia_pkg::STACK_PTR_RESET;
            s.faultRstEn <= pcsia_pkg::FAULT_RST_EN_RESET;
            s.bus <= PCSIA_BUS_IDLE;
            s.overflow <= porReset ? 1'b0 : s.overflow;
            s.underflow <= porReset ? 1'b0 : s.underflow;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign pready          = (s.bus == PCSIA_BUS_DONE);
    assign pslverr         = (s.bus == PCSIA_BUS_DONE) && s.err;
    assign prdata          = s.rdata;
    assign pcOut           = s.pc;
    assign stackFaultReset = s.faultPulse;
    assign memReq          = s.mem;
endmodule
`default_nettype wire

/* pkg/pcsia_pkg.sv */
// Constants and carrier types for the program-flow block.
// Assumes a single 100 MHz clock, synchronous reset, APB register access.
// Functional notes
// - Fifteen-bit PC, low byte visible, top from latch
// - Any reset clears whole PC
// - Low byte write loads upper bits from latch
// - Direct call: operand eleven bits, latch bits 6:3
// - Call via W: W low, latch high
// - Branch via W: PC+1 plus unsigned W
// - Relative branch: PC+1 plus signed operand
// - Sixteen by fifteen stack outside memory spaces
// - Push on calls/interrupt, pop on returns
// - Push and pop leave latch untouched
// - Fault reset off: stack wraps circularly
// - Overflow/underflow flags always set
// - Fault reset on: reset on over/underflow
// - Pointer and top pair reach any entry
// - Push increments first, pop decrements after
// - Indirect ports use sixteen-bit address pairs
// - Address of indirect port reads zero, no write
// - 0x0000-0x1FFF maps to banked memory
// - 0x2000-0x2FEF maps linear onto 80-byte blocks
// - Unimplemented linear memory reads zero
// - Top bit set: flash low byte, read-only, slower
// - High byte 0x70: EEPROM read-only, slower
package pcsia_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INDIRECT_PORT0 = 8'h00;
    localparam logic [7:0] IDX_INDIRECT_PORT1 = 8'h01;
    localparam logic [7:0] IDX_PC_LOW_BYTE    = 8'h02;
    localparam logic [7:0] IDX_IND_ADDR0_LOW  = 8'h04;
    localparam logic [7:0] IDX_IND_ADDR0_HIGH = 8'h05;
    localparam logic [7:0] IDX_IND_ADDR1_LOW  = 8'h06;
    localparam logic [7:0] IDX_IND_ADDR1_HIGH = 8'h07;
    localparam logic [7:0] IDX_PC_UPPER_LATCH = 8'h0A;
    localparam logic [7:0] IDX_STACK_POINTER  = 8'h10;
    localparam logic [7:0] IDX_STACK_TOP_LOW  = 8'h11;
    localparam logic [7:0] IDX_STACK_TOP_HIGH = 8'h12;
    localparam logic [7:0] IDX_STACK_CONTROL  = 8'h13;
    // Stack control field positions
    localparam int         BIT_FAULT_RST_EN   = 0;
    localparam int         BIT_OVERFLOW       = 1;
    localparam int         BIT_UNDERFLOW      = 2;
    // Reset values
    localparam logic [4:0] STACK_PTR_RESET    = 5'h1F;
    localparam logic       FAULT_RST_EN_RESET = 1'b1;
    localparam logic [14:0] PC_RESET          = 15'h0000;
    localparam logic [14:0] INT_VECTOR        = 15'h0004;
    // Stack shape and fault points
    localparam int         STACK_DEPTH        = 16;
    localparam logic [4:0] STACK_PTR_FULL     = 5'h0F;
    localparam logic [4:0] STACK_PTR_EMPTY    = 5'h1F;
    // Indirect address map
    localparam logic [15:0] LINEAR_BASE       = 16'h2000;
    localparam logic [15:0] LINEAR_LAST       = 16'h2FEF;
    localparam logic [15:0] BANKED_LAST       = 16'h1FFF;
    localparam logic [7:0]  EEPROM_HIGH       = 8'h70;
    localparam logic [11:0] LINEAR_BLOCK      = 12'h0050;
    localparam logic [12:0] BANK_SIZE         = 13'h0080;
    localparam logic [12:0] GPR_OFFSET        = 13'h0020;
    localparam logic [6:0]  LINEAR_BANKS      = 7'h19;
    localparam logic [6:0]  PORT_SLOTS        = 7'h02;

    // Operation kinds from the decoder
    typedef enum logic [3:0] {
        PCSIA_OP_FETCH, PCSIA_OP_WRITE_LOW, PCSIA_OP_CALL, PCSIA_OP_CALL_W,
        PCSIA_OP_BRANCH_W, PCSIA_OP_BRANCH_REL, PCSIA_OP_RETURN,
        PCSIA_OP_RETURN_LIT, PCSIA_OP_RETURN_INT, PCSIA_OP_INT_VECTOR
    } pcsia_op_t;

    // Memory space selector
    typedef enum logic [1:0] {
        PCSIA_SPACE_DATA, PCSIA_SPACE_FLASH, PCSIA_SPACE_EEPROM
    } pcsia_space_t;

    // Decoder request, one per instruction
    typedef struct packed {
        logic        valid;
        pcsia_op_t   kind;
        logic [10:0] operand;
        logic [7:0]  working;
        logic [7:0]  result;
    } pcsia_core_op_t;

    // Request to the memory system
    typedef struct packed {
        logic         strobe;
        logic         write;
        pcsia_space_t space;
        logic [14:0]  addr;
        logic [7:0]   wdata;
    } pcsia_mem_req_t;
endpackage

/* tb/pcsia_core_monitor.sv */
// Concurrent checks on the core outputs.
// Assumes a bind onto pcsia_core; one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pcsia_core_monitor (
    input wire logic                      sys_clk,
    input wire logic                      rst,
    input wire pcsia_pkg::pcsia_core_op_t coreOp,
    input wire logic [14:0]               pcOut,
    input wire logic                      stackFaultReset,
    input wire pcsia_pkg::pcsia_mem_req_t memReq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Operation seen at this edge
    wire logic                 act = coreOp.valid;
    wire pcsia_pkg::pcsia_op_t k   = coreOp.kind;
    // Sign-extended relative offset
    wire logic [14:0]          rel = {{6{coreOp.operand[8]}}, coreOp.operand[8:0]};

    pc_reset_a: assert property ($fell(rst) |-> pcOut == 15'h0000)
        else $error("pc not cleared");
    pc_fetch_a: assert property (act && k == pcsia_pkg::PCSIA_OP_FETCH |=> pcOut == $past(pcOut) + 15'h0001)
        else $error("fetch step wrong");
    write_low_a: assert property (act && k == pcsia_pkg::PCSIA_OP_WRITE_LOW |=> pcOut[7:0] == $past(coreOp.result))
        else $error("low byte lost");
    call_target_a: assert property (act && k == pcsia_pkg::PCSIA_OP_CALL |=> pcOut[10:0] == $past(coreOp.operand))
        else $error("call target wrong");
    call_via_working_reg_low_a: assert property (act && k == pcsia_pkg::PCSIA_OP_CALL_W |=> pcOut[7:0] == $past(coreOp.working))
        else $error("W call wrong");
    branch_w_a: assert property (act && k == pcsia_pkg::PCSIA_OP_BRANCH_W
        |=> pcOut == $past(pcOut) + 15'h0001 + {7'h00, $past(coreOp.working)})
        else $error("W branch wrong");
    branch_rel_a: assert property (act && k == pcsia_pkg::PCSIA_OP_BRANCH_REL
        |=> pcOut == $past(pcOut) + 15'h0001 + $past(rel))
        else $error("rel branch wrong");
    int_vector_a: assert property (act && k == pcsia_pkg::PCSIA_OP_INT_VECTOR |=> pcOut == pcsia_pkg::INT_VECTOR)
        else $error("vector wrong");
    rom_write_a: assert property (memReq.strobe && memReq.space != pcsia_pkg::PCSIA_SPACE_DATA |-> !memReq.write)
        else $error("write to read-only space");
    fault_pulse_a: assert property (stackFaultReset |=> !stackFaultReset)
        else $error("fault pulse too long");
    // Main scenarios reached
    cover property (act && k == pcsia_pkg::PCSIA_OP_CALL);
    cover property (stackFaultReset);
    cover property (memReq.strobe && memReq.space == pcsia_pkg::PCSIA_SPACE_FLASH);
endmodule
`default_nettype wire

/* tb/pcsia_mem_model.sv */
// Memory system stand-in answering indirect strobes.
// Assumes data is due the cycle after a strobe.
`timescale 1ns/1ps
`default_nettype none
module pcsia_mem_model (
    input wire logic                      sys_clk,
    input wire pcsia_pkg::pcsia_mem_req_t memReq,
    output logic [7:0]                    memRdata
);
    initial memRdata = 8'h3C;
    // Answer after a strobe, scramble otherwise
    always @(posedge sys_clk) begin
        if (memReq.strobe === 1'b1) begin
            memRdata <= memReq.addr[7:0] ^ 8'hA5;
        end else begin
            memRdata <= ~memRdata;
        end
    end
endmodule
`default_nettype wire

/* tb/test_pc_stack_indirect_addressing.sv */
// Self-checking bench for the program-flow block.
// Assumes the memory stand-in and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_pc_stack_indirect_addressing;
    logic                      sys_clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      porReset = 1'b1;
    logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]               paddr = 12'h000;
    logic [31:0]               pwdata = 32'h0000_0000, prdata;
    logic                      pready, pslverr, stackFaultReset, err, flt;
    pcsia_pkg::pcsia_core_op_t coreOp = '0;
    pcsia_pkg::pcsia_mem_req_t memReq, lastReq;
    logic [14:0]               pcOut, epc;
    logic [7:0]                memRdata, rd, lo;
    logic [15:0]               fsr;
    logic [17:0]               e;
    logic [14:0]               q[$];
    int                        n_errors = 0, n_compared = 0, nStb = 0, n0;
    logic [15:0] fsrTab [9] = '{16'h0001, 16'h0123, 16'h2000, 16'h27CF, 16'h27D0, 16'h2FF0, 16'h7042, 16'h8123, 16'hFFFF};
    always #5 sys_clk = ~sys_clk;
    pcsia_core u_dut (.sys_clk(sys_clk), .rst(rst), .porReset(porReset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .coreOp(coreOp), .pcOut(pcOut), .stackFaultReset(stackFaultReset), .memReq(memReq), .memRdata(memRdata));
    pcsia_mem_model u_mem (.sys_clk(sys_clk), .memReq(memReq), .memRdata(memRdata));
    // Record each memory strobe
    always @(posedge sys_clk) if (memReq.strobe === 1'b1) begin
        nStb <= nStb + 1;
        lastReq <= memReq;
    end
    task complete_run;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int i;
        @(posedge sys_clk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata[7:0];
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (i >= 20) begin
            chk(i, 0, "apb timeout");
            complete_run();
        end
    endtask
    // One decoder op; fault request sampled in its answer cycle
    task op(input pcsia_pkg::pcsia_op_t k, input logic [10:0] o, input logic [7:0] w);
        @(posedge sys_clk);
        coreOp <= '{1'b1, k, o, w, w};
        @(posedge sys_clk);
        coreOp.valid <= 1'b0;
        #1;
        flt = stackFaultReset;
    endtask
    // Expected {strobe, space, addr}
    function automatic logic [17:0] imap(input logic [15:0] f);
        int k;
        k = (f - 16'h2000) / 80;
        if (f[15]) return {1'b1, 2'h1, f[14:0]};
        if (f[15:8] == 8'h70) return {1'b1, 2'h2, 7'h00, f[7:0]};
        if (f < 16'h2000) return {f[6:0] > 7'h01, 2'h0, f[14:0]};
        if (f <= 16'h2FEF && k < 25) return {1'b1, 2'h0, 15'(k * 128 + 32 + (f - 16'h2000) % 80)};
        return 18'h0_0000;
    endfunction
    pcsia_pkg::pcsia_op_t kinds [3] = '{pcsia_pkg::PCSIA_OP_FETCH, pcsia_pkg::PCSIA_OP_BRANCH_W,
                                        pcsia_pkg::PCSIA_OP_BRANCH_REL};
    initial begin
        logic [31:0] r;
        void'($urandom(77028));
        repeat (16) @(posedge sys_clk);
        {rst, porReset} <= 2'b00;
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 8'h1F, "pointer at reset");
        chk(pcOut, 15'h0000, "pc at reset");
        apb(1'b0, 8'h20, 8'h00);
        chk(err, 1'b1, "unmapped error");
        apb(1'b1, 8'h0A, 8'h7F);
        op(pcsia_pkg::PCSIA_OP_WRITE_LOW, 11'h000, 8'hFF);
        chk(pcOut, 15'h7FFF, "low byte load");
        op(pcsia_pkg::PCSIA_OP_FETCH, 11'h000, 8'h00);
        chk(pcOut, 15'h0000, "fetch wrap");
        apb(1'b1, 8'h0A, 8'h55);
        q.push_back(15'h0001);
        op(pcsia_pkg::PCSIA_OP_CALL, 11'h3C4, 8'h00);
        chk(pcOut, 15'h53C4, "call target");
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 8'h00, "pointer after push");
        apb(1'b0, 8'h11, 8'h00);
        lo = rd;
        apb(1'b0, 8'h12, 8'h00);
        chk({rd, lo}, 16'h0001, "top pair");
        apb(1'b0, 8'h0A, 8'h00);
        chk(rd, 8'h55, "latch kept");
        q.push_back(15'h53C5);
        op(pcsia_pkg::PCSIA_OP_CALL_W, 11'h000, 8'h9B);
        chk(pcOut, 15'h559B, "call via W");
        q.push_back(15'h559C);
        op(pcsia_pkg::PCSIA_OP_INT_VECTOR, 11'h000, 8'h00);
        foreach (kinds[j]) begin
            op(j == 0 ? pcsia_pkg::PCSIA_OP_RETURN_INT : j == 1 ? pcsia_pkg::PCSIA_OP_RETURN_LIT :
               pcsia_pkg::PCSIA_OP_RETURN, 11'h000, 8'h33);
            chk(pcOut, q.pop_back(), "return");
        end
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 8'h1F, "pointer emptied");
        epc = pcOut;
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            op(kinds[r % 3], r[26:16], r[15:8]);
            epc += 15'h0001 + (r % 3 == 1 ? {7'h00, r[15:8]} : r % 3 == 2 ? {{6{r[24]}}, r[24:16]} : 15'h0000);
            chk(pcOut, epc, "pc step");
        end
        apb(1'b1, 8'h13, 8'h00);
        for (int i = 0; i < 17; i++) begin
            q.push_back(pcOut + 15'h0001);
            op(pcsia_pkg::PCSIA_OP_CALL, 11'(i * 37), 8'h00);
            chk(flt, 1'b0, "no fault reset when off");
        end
        apb(1'b0, 8'h11, 8'h00);
        lo = rd;
        apb(1'b0, 8'h12, 8'h00);
        chk({rd, lo}, q[$], "circular overwrite");
        apb(1'b0, 8'h13, 8'h00);
        chk(rd, 8'h02, "overflow flag");
        apb(1'b1, 8'h13, 8'h01);
        apb(1'b1, 8'h10, 8'h1F);
        op(pcsia_pkg::PCSIA_OP_RETURN, 11'h000, 8'h00);
        chk(flt, 1'b1, "underflow fault reset");
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h13, 8'h00);
        chk(rd, 8'h05, "underflow flag kept");
        chk(pcOut, 15'h0000, "pc after fault reset");
        for (int i = 0; i < 17; i++) begin
            fsr = i < 9 ? fsrTab[i] : i == 15 ? 16'h0123 : i == 16 ? 16'h8123 : 16'($urandom);
            e = imap(fsr);
            n0 = nStb;
            apb(1'b1, 8'(5 + 2 * (i % 2)), fsr[15:8]);
            apb(1'b1, 8'(4 + 2 * (i % 2)), fsr[7:0]);
            apb(i > 14, 8'(i % 2), 8'h5E);
            if (i < 15) chk(rd, e[17] ? e[7:0] ^ 8'hA5 : 8'h00, "port read");
            chk(nStb - n0, i == 16 ? 0 : e[17], "strobe count");
            if (nStb != n0) chk({lastReq.write, lastReq.space, lastReq.addr, lastReq.wdata},
                {i == 15, e[16:0], 8'h5E}, "request");
        end
        complete_run();
    end
endmodule
bind pcsia_core pcsia_core_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .coreOp(coreOp), .pcOut(pcOut),
    .stackFaultReset(stackFaultReset), .memReq(memReq));
`default_nettype wire
